// file: pkg/ssd_params.svh
/*
  constants of the seven-segment command block: codes, fonts, texts, ranges.
  assumes inclusion by the package, the design module and the bench.
*/
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH
// ----------------------------------------
// constant command codes
// ----------------------------------------
`define SSD_K_CLEAR 12'h000
`define SSD_K_TXT1 12'h001
`define SSD_K_TXT2 12'h002
`define SSD_K_HELP 12'h003
`define SSD_K_HLP2 12'h004
`define SSD_K_ERROR 12'h005
`define SSD_K_ERR2 12'h006
`define SSD_K_LZERO 12'h007
`define SSD_K_TWO 12'h008
`define SSD_K_DP0 12'h00A
`define SSD_K_DP5 12'h00F
`define SSD_K_FREE 12'h014
`define SSD_K_SHIFT 12'h015
`define SSD_K_FREE2 12'h016
// ----------------------------------------
// segment font: a=0 f=1 g=2 e=3 d=4 b=5 c=6 dp=7
// ----------------------------------------
`define SSD_DIGIT_FONT 80'h777F615F5766753D607B
`define SSD_MINUS 8'h04
`define SSD_TXT1 48'h00576F606F00
`define SSD_TXT2 48'h002F1B7C3D00
`define SSD_TXT_HELP 48'h00006E1F1A2F
`define SSD_TXT_ERROR 48'h001F0C0C5C0C
`define SSD_TXT_HLP2 48'h6E1A2F000000
`define SSD_TXT_ERR2 48'h1F0C0C000000
// ----------------------------------------
// value ranges and reset values
// ----------------------------------------
`define SSD_SIX_MAX 32'sh000F423F
`define SSD_SIX_MIN (-32'sh0001869F)
`define SSD_TWO_MAX 32'sh00000063
`define SSD_FREE_MAX 32'sh000000FF
`define SSD_DP_RST 6'h00
`endif

// file: pkg/ssd_pkg.sv
/*
  types of the seven-segment command block.
  assumes ssd_params.svh sits beside it on the include path.
*/
package ssd_pkg;
  `include "ssd_params.svh"
  // mode, gray coded along six -> two -> free
  typedef enum logic [1:0] {
    SSD_MODE_SIX = 2'h0,
    SSD_MODE_TWO = 2'h1,
    SSD_MODE_FREE = 2'h3
  } ssd_mode_t;
  typedef struct packed {
    logic is_reg;
    logic [11:0] arg;
  } ssd_cmd_t;
endpackage

// file: design/ssd_cmd.sv
/*
  command interpreter for a six-digit seven-segment display.
  assumes one clock, commands and register data from logic on that clock.
*/
// Operation
// - three modes: six-digit, two-digit with prefix, free segment mode
// - constant codes act the same in every mode except 21 and 12..15; many change mode
// - code 0 blanks digits, clears points, selects six-digit mode
// - codes 1,2,3,5 show a fixed text, six-digit mode
// - codes 4,6 show a prefix, two-digit mode; then value 0..99
// - register reference selects register 0 to 4095
// - code 7 clears, six-digit mode, leading zeros until the next code 0
// - code 8 clears and selects two-digit mode
// - codes 10..15 light point of digit 0..5; only code 0 clears
// - points on digits 2..5 only while in six-digit mode
// - code 20 selects free mode; code 22 free behaviour, two-digit shown
// - code 21 in free mode shifts patterns left, right digit blank
// - six-digit mode shows signed value right-justified, -99999..999999
// - out-of-range value leaves display unchanged and sets error flag
// - two-digit mode shows 0..99 in two right digits, rest kept
// - free mode value up to 255 drives rightmost digit segments
`include "ssd_params.svh"
module ssd_cmd
  import ssd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic srst, // synchronous reset
  input wire logic cmd_valid, // command request
  input wire ssd_cmd_t cmd, // command form and argument
  output logic [11:0] reg_addr, // register number to read
  input wire logic signed [31:0] reg_data, // register contents
  input wire logic error_clear, // clears error flag
  output logic cmd_done, // command executed
  output logic error_flag, // sticky range error
  output ssd_mode_t mode, // reported mode
  output logic lead_zero, // leading zeros enabled
  output logic [5:0] dp_on, // decimal points
  output logic [47:0] segments // digit 5..0 patterns
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] font(
    input logic [3:0] d
  );
    logic [79:0] tab;
    tab = `SSD_DIGIT_FONT;
    font = (d > 4'h9) ? 8'h00 : tab[d*8 +: 8];
  endfunction

  function automatic logic [47:0] fmt_dec(
    input logic [19:0] mag,
    input logic neg,
    input logic lz
  );
    logic [19:0] v;
    logic [47:0] r;
    logic placed;
    v = mag;
    r = 48'h0;
    placed = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (i == 0 || v != 20'h0 || lz) begin
        r[i*8 +: 8] = font(4'(v % 20'hA));
      end else if (neg && !placed) begin
        r[i*8 +: 8] = `SSD_MINUS;
        placed = 1'b1;
      end
      v = v / 20'hA;
    end
    if (neg && lz) begin
      r[47:40] = `SSD_MINUS;
    end
    fmt_dec = r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  ssd_mode_t mode_reg, mode_next;
  logic free_beh_reg, free_beh_next;
  logic lz_reg, lz_next;
  logic [5:0] dp_reg, dp_next;
  logic [47:0] dig_reg, dig_next;
  logic err_reg;
  logic done_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire k_cmd = cmd_valid && !cmd.is_reg;
  wire r_cmd = cmd_valid && cmd.is_reg;
  wire [11:0] k = cmd.arg;
  wire is_free = (mode_reg == SSD_MODE_FREE) || free_beh_reg;
  wire k_dp = (k >= `SSD_K_DP0) && (k <= `SSD_K_DP5);
  wire [2:0] dp_idx = 3'(k - `SSD_K_DP0);
  wire dp_allowed = (dp_idx < 3'h2) || (mode_reg == SSD_MODE_SIX);

  assign reg_addr = cmd.arg;

  wire neg = reg_data < 32'sh0;
  wire [19:0] mag = 20'(neg ? -reg_data : reg_data);
  wire six_ok = (reg_data >= `SSD_SIX_MIN) && (reg_data <= `SSD_SIX_MAX);
  wire two_ok = !neg && (reg_data <= `SSD_TWO_MAX);
  wire free_ok = !neg && (reg_data <= `SSD_FREE_MAX);

  // value check depends on mode; free behaviour wins over two-digit
  wire val_ok = is_free ? free_ok :
    (mode_reg == SSD_MODE_TWO) ? two_ok : six_ok;
  wire r_err = r_cmd && !val_ok;

  wire [47:0] dec_six = fmt_dec(mag, neg, lz_reg);
  wire [47:0] dec_two = fmt_dec(mag, 1'b0, lz_reg);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    mode_next = mode_reg;
    free_beh_next = free_beh_reg;
    lz_next = lz_reg;
    dp_next = dp_reg;
    dig_next = dig_reg;
    if (k_cmd) begin
      // constant codes ignore the current mode, except shift and points 2..5
      case (k)
        `SSD_K_CLEAR: begin
          dig_next = 48'h0;
          dp_next = `SSD_DP_RST;
          lz_next = 1'b0;
          mode_next = SSD_MODE_SIX;
          free_beh_next = 1'b0;
        end
        `SSD_K_TXT1, `SSD_K_TXT2, `SSD_K_HELP, `SSD_K_ERROR: begin
          dig_next = (k == `SSD_K_TXT1) ? `SSD_TXT1 :
            (k == `SSD_K_TXT2) ? `SSD_TXT2 :
            (k == `SSD_K_HELP) ? `SSD_TXT_HELP : `SSD_TXT_ERROR;
          mode_next = SSD_MODE_SIX;
          free_beh_next = 1'b0;
        end
        `SSD_K_HLP2, `SSD_K_ERR2: begin
          dig_next = (k == `SSD_K_HLP2) ? `SSD_TXT_HLP2 : `SSD_TXT_ERR2;
          mode_next = SSD_MODE_TWO;
          free_beh_next = 1'b0;
        end
        `SSD_K_LZERO: begin
          dig_next = 48'h0;
          lz_next = 1'b1;
          mode_next = SSD_MODE_SIX;
          free_beh_next = 1'b0;
        end
        `SSD_K_TWO: begin
          dig_next = 48'h0;
          mode_next = SSD_MODE_TWO;
          free_beh_next = 1'b0;
        end
        `SSD_K_FREE: begin
          mode_next = SSD_MODE_FREE;
          free_beh_next = 1'b0;
        end
        `SSD_K_FREE2: begin
          mode_next = SSD_MODE_TWO;
          free_beh_next = 1'b1;
        end
        `SSD_K_SHIFT: begin
          if (is_free) begin
            dig_next = {dig_reg[39:0], 8'h00};
          end
        end
        default: begin
          if (k_dp && dp_allowed) begin
            dp_next[dp_idx] = 1'b1;
          end
        end
      endcase
    end else if (r_cmd && val_ok) begin
      if (is_free) begin
        dig_next[7:0] = reg_data[7:0];
      end else if (mode_reg == SSD_MODE_TWO) begin
        dig_next[15:0] = dec_two[15:0];
      end else begin
        dig_next = dec_six;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= SSD_MODE_SIX;
      free_beh_reg <= 1'b0;
      lz_reg <= 1'b0;
      dp_reg <= `SSD_DP_RST;
      dig_reg <= 48'h0;
    end else begin
      mode_reg <= mode_next;
      free_beh_reg <= free_beh_next;
      lz_reg <= lz_next;
      dp_reg <= dp_next;
      dig_reg <= dig_next;
    end
  end

  // error set wins over clear
  always_ff @(posedge clock) begin
    if (srst) begin
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      err_reg <= r_err || (err_reg && !error_clear);
      done_reg <= cmd_valid;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign mode = mode_reg;
  assign lead_zero = lz_reg;
  assign dp_on = dp_reg;
  assign error_flag = err_reg;
  assign cmd_done = done_reg;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_seg
      assign segments[g*8 +: 8] = {dig_reg[g*8+7] | dp_reg[g], dig_reg[g*8 +: 7]};
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_k(logic [11:0] c);
    cmd_valid && !cmd.is_reg && cmd.arg == c;
  endsequence

  sequence s_r;
    cmd_valid && cmd.is_reg;
  endsequence

  chk_clear_blank: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_CLEAR) |=> dig_reg == 48'h0 && dp_reg == 6'h0 && mode_reg == SSD_MODE_SIX)
    else $error("clear code did not blank display");

  chk_text_six: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_HELP) |=> mode_reg == SSD_MODE_SIX && dig_reg == `SSD_TXT_HELP)
    else $error("text code wrong result");

  chk_prefix_two: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_ERR2) |=> mode_reg == SSD_MODE_TWO && dig_reg[47:16] == 32'h1F0C0C00)
    else $error("prefix code wrong result");

  chk_lead_zero: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_LZERO) |=> lz_reg && dig_reg == 48'h0 && mode_reg == SSD_MODE_SIX)
    else $error("leading zero code wrong result");

  chk_two_clear: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_TWO) |=> mode_reg == SSD_MODE_TWO && dig_reg == 48'h0)
    else $error("two digit code wrong result");

  chk_point_zero: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_DP0) |=> dp_reg[0] && mode_reg == $past(mode_reg))
    else $error("point zero not lit");

  chk_point_guard: assert property (@(posedge clock) disable iff (srst)
    (s_k(`SSD_K_DP5) and (mode_reg != SSD_MODE_SIX)) |=> dp_reg == $past(dp_reg))
    else $error("point lit outside six digit mode");

  chk_free_select: assert property (@(posedge clock) disable iff (srst)
    s_k(`SSD_K_FREE2) |=> mode_reg == SSD_MODE_TWO && is_free)
    else $error("free behaviour not entered");

  chk_free_shift: assert property (@(posedge clock) disable iff (srst)
    (s_k(`SSD_K_SHIFT) and is_free) |=> dig_reg == {$past(dig_reg[39:0]), 8'h00})
    else $error("shift wrong");

  chk_range_err: assert property (@(posedge clock) disable iff (srst)
    (s_r and !val_ok) |=> err_reg && dig_reg == $past(dig_reg))
    else $error("range error not reported");

  chk_two_keep: assert property (@(posedge clock) disable iff (srst)
    (s_r and (!is_free && mode_reg == SSD_MODE_TWO))
    |=> dig_reg[47:16] == $past(dig_reg[47:16]))
    else $error("prefix digits changed");

  chk_free_direct: assert property (@(posedge clock) disable iff (srst)
    (s_r and (is_free && free_ok)) |=> dig_reg[7:0] == $past(reg_data[7:0]))
    else $error("free pattern not loaded");

  chk_six_units: assert property (@(posedge clock) disable iff (srst)
    (s_r and (!is_free && mode_reg == SSD_MODE_SIX && reg_data == 32'sh2A))
    |=> dig_reg[15:0] == 16'h663D)
    else $error("units digit wrong");

  chk_done_pulse: assert property (@(posedge clock) disable iff (srst)
    cmd_valid |=> cmd_done)
    else $error("command not acknowledged");

endmodule

// file: tb/ssd_proc_model.sv
/*
  processor-side register file that answers the block's register reads.
  assumes the bench loads registers through the write port.
*/
module ssd_proc_model
  import ssd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic wr_en, // bench loads a register
  input wire logic [11:0] wr_addr, // register to load
  input wire logic signed [31:0] wr_data, // value to load
  input wire logic [11:0] reg_addr, // register asked for
  output logic signed [31:0] reg_data // answer in the same cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] regs [4096];
  always_ff @(posedge clock) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end
  assign reg_data = regs[reg_addr];
endmodule

// file: tb/ssd_cmd_tb.sv
/*
  self-checking bench of the display command block.
  assumes ssd_proc_model and the package are compiled first.
*/
`include "ssd_params.svh"
module ssd_cmd_tb;
  import ssd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  ssd_cmd_t cmd = '0;
  logic error_clear = 1'b0;
  logic wr_en = 1'b0;
  logic [11:0] wr_addr = 12'h000;
  logic signed [31:0] wr_data = 32'sh0;
  logic [11:0] reg_addr;
  logic signed [31:0] reg_data;
  logic cmd_done, error_flag, lead_zero;
  ssd_mode_t mode;
  logic [5:0] dp_on;
  logic [47:0] segments;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  ssd_cmd DUT (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .reg_addr(reg_addr), .reg_data(reg_data), .error_clear(error_clear),
    .cmd_done(cmd_done), .error_flag(error_flag), .mode(mode),
    .lead_zero(lead_zero), .dp_on(dp_on), .segments(segments));
  ssd_proc_model proc (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .reg_addr(reg_addr), .reg_data(reg_data));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic is_reg, input logic [11:0] arg);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= '{is_reg: is_reg, arg: arg};
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
    chk({47'h0, cmd_done}, 48'h1);
  endtask

  task automatic rcmd(input logic [11:0] a, input logic signed [31:0] v);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= v;
    @(posedge clock);
    wr_en <= 1'b0;
    send(1'b1, a);
  endtask

  task automatic st(input logic [47:0] seg, input logic [1:0] md, input logic err);
    chk(segments, seg);
    chk({46'h0, mode}, {46'h0, md});
    chk({47'h0, error_flag}, {47'h0, err});
  endtask

  task automatic clr_err();
    @(posedge clock);
    error_clear <= 1'b1;
    @(posedge clock);
    error_clear <= 1'b0;
    #1;
    chk({47'h0, error_flag}, 48'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_texts();
    logic [11:0] codes [4] = '{12'h001, 12'h002, 12'h003, 12'h005};
    logic [47:0] txt [4] = '{`SSD_TXT1, `SSD_TXT2, `SSD_TXT_HELP, `SSD_TXT_ERROR};
    st(48'h0, 2'h0, 1'b0);
    chk({41'h0, lead_zero, dp_on}, 48'h0);
    for (int i = 0; i < 4; i++) begin
      send(1'b0, codes[i]);
      st(txt[i], 2'h0, 1'b0);
    end
  endtask

  task automatic t_six();
    send(1'b0, 12'h000);
    rcmd(12'h005, 32'sd42);
    st(48'h0000_0000_663D, 2'h0, 1'b0);
    rcmd(12'hFFF, 32'sd999999);
    st(48'h7777_7777_7777, 2'h0, 1'b0);
    rcmd(12'h001, -32'sd99999);
    st(48'h0477_7777_7777, 2'h0, 1'b0);
    rcmd(12'h002, 32'sd1000000);
    st(48'h0477_7777_7777, 2'h0, 1'b1);
    clr_err();
    rcmd(12'h003, -32'sd100000);
    st(48'h0477_7777_7777, 2'h0, 1'b1);
    clr_err();
    send(1'b0, 12'h007);
    chk({47'h0, lead_zero}, 48'h1);
    st(48'h0, 2'h0, 1'b0);
    rcmd(12'h005, 32'sd42);
    st(48'h7B7B_7B7B_663D, 2'h0, 1'b0);
    rcmd(12'h006, -32'sd5);
    st(48'h047B_7B7B_7B57, 2'h0, 1'b0);
  endtask

  task automatic t_two();
    send(1'b0, 12'h000);
    send(1'b0, 12'h008);
    st(48'h0, 2'h1, 1'b0);
    rcmd(12'h006, 32'sd7);
    st(48'h0000_0000_0061, 2'h1, 1'b0);
    rcmd(12'h007, 32'sd99);
    st(48'h0000_0000_7777, 2'h1, 1'b0);
    rcmd(12'h008, 32'sd100);
    st(48'h0000_0000_7777, 2'h1, 1'b1);
    clr_err();
    send(1'b0, 12'h004);
    st(`SSD_TXT_HLP2, 2'h1, 1'b0);
    rcmd(12'h009, 32'sd56);
    st(48'h6E1A_2F00_575F, 2'h1, 1'b0);
    send(1'b0, 12'h006);
    rcmd(12'h00A, -32'sd1);
    st(`SSD_TXT_ERR2, 2'h1, 1'b1);
    clr_err();
    rcmd(12'h00B, 32'sd8);
    st(48'h1F0C_0C00_007F, 2'h1, 1'b0);
  endtask

  task automatic t_dp();
    send(1'b0, 12'h000);
    send(1'b0, 12'h008);
    for (int c = 10; c < 16; c++) send(1'b0, 12'(c));
    chk({42'h0, dp_on}, 48'h03);
    send(1'b0, 12'h000);
    for (int c = 10; c < 16; c++) send(1'b0, 12'(c));
    chk({42'h0, dp_on}, 48'h3F);
    send(1'b0, 12'h003);
    st(48'h8080_EE9F_9AAF, 2'h0, 1'b0);
    send(1'b0, 12'h000);
    chk({42'h0, dp_on}, 48'h0);
    chk(segments, 48'h0);
  endtask

  task automatic t_free();
    send(1'b0, 12'h003);
    send(1'b0, 12'h015);
    st(`SSD_TXT_HELP, 2'h0, 1'b0);
    send(1'b0, 12'h000);
    send(1'b0, 12'h014);
    rcmd(12'h00C, 32'sh75);
    st(48'h75, 2'h3, 1'b0);
    send(1'b0, 12'h015);
    rcmd(12'h00D, 32'sh60);
    st(48'h7560, 2'h3, 1'b0);
    rcmd(12'h00E, 32'sh100);
    st(48'h7560, 2'h3, 1'b1);
    clr_err();
    send(1'b0, 12'h003);
    st(`SSD_TXT_HELP, 2'h0, 1'b0);
    send(1'b0, 12'h000);
    send(1'b0, 12'h016);
    rcmd(12'h00C, 32'sh75);
    send(1'b0, 12'h015);
    send(1'b0, 12'h010);
    st(48'h7500, 2'h1, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    #1;
    t_texts();
    t_six();
    t_two();
    t_dp();
    t_free();
    wrap_up();
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule
